/* File: verilog/pct_map.svh */
// configuration register offsets, field positions and counts for the pnp loader
// assumes inclusion by the package, the shift chain and the top module only
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH
`define PCT_IDX_RES_BYTE 8'h04
`define PCT_IDX_RES_STAT 8'h05
`define PCT_IDX_ACTIVATE 8'h30
`define PCT_IDX_RAM_HI 8'h40
`define PCT_IDX_RAM_LO 8'h41
`define PCT_IDX_RAM_SIZE 8'h44
`define PCT_IDX_ROM_HI 8'h48
`define PCT_IDX_ROM_LO 8'h49
`define PCT_IDX_ROM_SIZE 8'h4c
`define PCT_IDX_IO_HI 8'h60
`define PCT_IDX_IO_LO 8'h61
`define PCT_IDX_IRQ 8'h70
`define PCT_CHAIN_BITS 22
`define PCT_CNT_W 5
`define PCT_VALID_BIT 0
`define PCT_ACT_BIT 0
`define PCT_ROM_OFF_SIZE 2'b11
`endif

/* File: verilog/pct_pkg.sv */
// types shared by the pnp configuration loader
// assumes pct_map.svh for widths
`default_nettype none
`include "pct_map.svh"
package pct_pkg;
    typedef enum logic [1:0] {
        PCT_WAIT_KEY, PCT_SLEEP, PCT_ISOLATE, PCT_CONFIG
    } pct_pnp_state_e;
    typedef logic [`PCT_CHAIN_BITS-1:0] pct_chain_t;
    // internal register images fed by the chain
    typedef struct packed {
        logic [7:0] ram_window;
        logic [7:0] rom_window;
        logic [7:0] io_window;
        logic [7:0] general;
    } pct_internal_s;
    // host side port access
    typedef struct packed {
        logic addr_wr;
        logic data_wr;
        logic data_rd;
        logic [7:0] wdata;
    } pct_host_s;
endpackage
`default_nettype wire

/* File: verilog/pct_shift_chain.sv */
// bidirectional 22 bit serial chain between pnp and internal register images
// assumes start pulses only while idle; one bit per enabled clock
`default_nettype none
`include "pct_map.svh"
module pct_shift_chain (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start_fwd,
    input wire logic start_rev,
    input wire pct_pkg::pct_chain_t load_fwd,
    input wire pct_pkg::pct_chain_t load_rev,
    output logic busy,
    output logic done_fwd,
    output logic done_rev,
    output pct_pkg::pct_chain_t result
);
    import pct_pkg::*;
    pct_chain_t src;
    logic dir_rev;
    logic [`PCT_CNT_W-1:0] count;
    always_ff @(posedge clk) begin
        if (rst) begin
            src <= '0;
            result <= '0;
            busy <= 1'b0;
            dir_rev <= 1'b0;
            count <= '0;
            done_fwd <= 1'b0;
            done_rev <= 1'b0;
        end else if (ce) begin
            done_fwd <= 1'b0;
            done_rev <= 1'b0;
            if (!busy && (start_fwd || start_rev)) begin
                busy <= 1'b1;
                dir_rev <= start_rev;
                src <= start_rev ? load_rev : load_fwd;
                count <= '0;
            end else if (busy) begin
                // one bit per clock, msb first, no parallel copy
                result <= {result[`PCT_CHAIN_BITS-2:0], src[`PCT_CHAIN_BITS-1]};
                src <= {src[`PCT_CHAIN_BITS-2:0], 1'b0};
                count <= count + 5'd1;
                if (count == 5'(`PCT_CHAIN_BITS - 1)) begin
                    busy <= 1'b0;
                    done_fwd <= !dir_rev;
                    done_rev <= dir_rev;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/pct_index_port.sv */
// address port index register for the 256 entry configuration space
// assumes host strobes are one cycle and same clock
`default_nettype none
module pct_index_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic addr_wr,
    input wire logic [7:0] wdata,
    output logic [7:0] index
);
    always_ff @(posedge clk) begin
        if (rst) begin
            index <= 8'h00;
        end else if (ce && addr_wr) begin
            index <= wdata;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/pct_loader.sv */
// pnp configuration registers, resource string port and activation chain
// assumes key detection and isolation logic drive pnp_state from outside
//
// What this block does
// - the next resource byte is read at index 04 and its valid flag at index 05 bit 0.
// - resource bytes are supplied only while the pnp state is configuration.
// - writing a one to bit 0 of index 30 is the activation command.
// - activation moves the settings to the internal registers over a serial chain.
// - the rest of the device stays inactive until that transfer completes.
// - configuration register accesses outside the allowed states are ignored.
// - unimplemented registers and unused bits read as zero.
// - with both size bits of the internal rom window set the rom configuration registers read zero and are read only.
// - the chain carries exactly 22 bits on each activation.
// - after the initial eerom load the chain runs backwards with inverse remapping.
// - base bits map directly onto the ram, rom and io window registers.
// - ram and rom size codes are remapped 00-10, 01-11, 10-01, 11-00.
// - the irq level is remapped to a 3 bit code in general control bits 6, 3, 2.
// - in io pipe mode configuration register reads return zero and writes are ignored.
// - address port writes set an index into a 256 entry configuration space.
`default_nettype none
`include "pct_map.svh"
module pct_loader (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire pct_pkg::pct_host_s host,
    input wire pct_pkg::pct_pnp_state_e pnp_state,
    input wire logic io_pipe_mode,
    input wire logic [7:0] res_byte_in,
    input wire logic res_byte_avail,
    input wire logic eerom_load_done,
    input wire pct_pkg::pct_internal_s int_defaults,
    output logic [7:0] rdata,
    output logic res_byte_taken,
    output pct_pkg::pct_internal_s int_cfg,
    output logic device_active,
    output logic chain_busy
);
    import pct_pkg::*;

    // ****************************************
    // remapping functions
    // ****************************************
    // pnp size code to internal size code; size_rev undoes it
    function automatic logic [1:0] size_fwd(input logic [1:0] p);
        size_fwd = {~p[1], p[1] ^ p[0]};
    endfunction
    function automatic logic [1:0] size_rev(input logic [1:0] i);
        size_rev = {~i[1], ~i[1] ^ i[0]};
    endfunction
    function automatic logic [2:0] irq_fwd(input logic [3:0] l);
        unique case (l)
            4'h2, 4'h9: irq_fwd = 3'h1;
            4'h3: irq_fwd = 3'h2;
            4'h5: irq_fwd = 3'h3;
            4'h7: irq_fwd = 3'h4;
            4'ha: irq_fwd = 3'h5;
            4'hb: irq_fwd = 3'h6;
            4'hf: irq_fwd = 3'h7;
            default: irq_fwd = 3'h0;
        endcase
    endfunction
    // code 001 stands for two levels; the way back picks 9
    function automatic logic [3:0] irq_rev(input logic [2:0] c);
        unique case (c)
            3'h1: irq_rev = 4'h9;
            3'h2: irq_rev = 4'h3;
            3'h3: irq_rev = 4'h5;
            3'h4: irq_rev = 4'h7;
            3'h5: irq_rev = 4'ha;
            3'h6: irq_rev = 4'hb;
            3'h7: irq_rev = 4'hf;
            default: irq_rev = 4'h0;
        endcase
    endfunction

    // ****************************************
    // index and pnp registers
    // ****************************************
    logic [7:0] index;
    pct_index_port u_index (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .addr_wr(host.addr_wr),
        .wdata(host.wdata),
        .index(index)
    );

    logic [1:0] ram_hi, rom_hi, ram_size, rom_size;
    logic [2:0] ram_lo, rom_lo, io_lo;
    logic io_hi;
    logic [3:0] irq_level;
    logic activate;
    logic [7:0] res_hold;
    logic res_valid;
    logic cfg_ok;
    logic rom_off;
    logic wr_ok;
    pct_chain_t chain_out;
    pct_chain_t fwd_bits;
    pct_chain_t rev_bits;
    logic done_fwd;
    logic done_rev;
    logic start_fwd;
    logic start_rev;
    logic busy;
    logic act_wr;
    logic eerom_seen;

    assign cfg_ok = (pnp_state == PCT_CONFIG) && !io_pipe_mode;
    assign rom_off = (int_cfg.rom_window[5:4] == `PCT_ROM_OFF_SIZE);
    // writes are dropped while the chain runs, so a shifted image never tears
    assign wr_ok = ce && host.data_wr && cfg_ok && !busy && !start_rev;
    assign act_wr = wr_ok && (index == `PCT_IDX_ACTIVATE);

    // ****************************************
    // host writes
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_hi <= '0;
            ram_lo <= '0;
            ram_size <= '0;
            io_hi <= 1'b0;
            io_lo <= '0;
            irq_level <= '0;
        end else if (done_rev && ce) begin
            // the defaults win over a host write in the same cycle
            {ram_hi[1], ram_hi[0], ram_lo} <= chain_out[21:17];
            ram_size <= size_rev(chain_out[16:15]);
            {io_hi, io_lo} <= chain_out[7:4];
            irq_level <= irq_rev(chain_out[2:0]);
        end else if (wr_ok) begin
            unique case (index)
                `PCT_IDX_RAM_HI: ram_hi <= host.wdata[1:0];
                `PCT_IDX_RAM_LO: ram_lo <= host.wdata[7:5];
                `PCT_IDX_RAM_SIZE: ram_size <= host.wdata[6:5];
                `PCT_IDX_IO_HI: io_hi <= host.wdata[0];
                `PCT_IDX_IO_LO: io_lo <= host.wdata[7:5];
                `PCT_IDX_IRQ: irq_level <= host.wdata[3:0];
                default: ;
            endcase
        end
    end

    // rom registers kept apart: while the rom is disabled only the eerom reverse load changes them
    always_ff @(posedge clk) begin
        if (rst) begin
            rom_hi <= '0;
            rom_lo <= '0;
            rom_size <= '0;
        end else if (done_rev && ce) begin
            {rom_hi, rom_lo} <= chain_out[14:10];
            rom_size <= size_rev(chain_out[9:8]);
        end else if (wr_ok && !rom_off) begin
            unique case (index)
                `PCT_IDX_ROM_HI: rom_hi <= host.wdata[1:0];
                `PCT_IDX_ROM_LO: rom_lo <= host.wdata[7:5];
                `PCT_IDX_ROM_SIZE: rom_size <= host.wdata[6:5];
                default: ;
            endcase
        end
    end

    // ****************************************
    // activation
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            activate <= 1'b0;
        end else if (act_wr) begin
            activate <= host.wdata[`PCT_ACT_BIT];
        end
    end
    // a one written to the activate bit launches the chain each time
    assign start_fwd = act_wr && host.wdata[`PCT_ACT_BIT];

    // one shot: a later eerom recall must not overwrite host settings
    always_ff @(posedge clk) begin
        if (rst) begin
            eerom_seen <= 1'b0;
        end else if (ce && eerom_load_done && !eerom_seen && !busy) begin
            eerom_seen <= 1'b1;
        end
    end
    assign start_rev = ce && eerom_load_done && !eerom_seen && !busy;

    // msb first order: ram base, ram size, rom base, rom size, io base, irq
    assign fwd_bits = {ram_hi, ram_lo, size_fwd(ram_size), rom_hi, rom_lo,
        size_fwd(rom_size), io_hi, io_lo, 1'b0, irq_fwd(irq_level)};
    assign rev_bits = {int_defaults.ram_window[6], int_defaults.ram_window[3:0],
        int_defaults.ram_window[5:4], int_defaults.rom_window[6],
        int_defaults.rom_window[3:0], int_defaults.rom_window[5:4],
        int_defaults.io_window[4:1], 1'b0, int_defaults.general[6],
        int_defaults.general[3:2]};

    pct_shift_chain u_chain (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start_fwd(start_fwd),
        .start_rev(start_rev),
        .load_fwd(fwd_bits),
        .load_rev(rev_bits),
        .busy(busy),
        .done_fwd(done_fwd),
        .done_rev(done_rev),
        .result(chain_out)
    );

    // ****************************************
    // internal registers and activity gate
    // ****************************************
    // bit positions follow the chain order of fwd_bits
    always_ff @(posedge clk) begin
        if (rst) begin
            int_cfg <= '0;
        end else if (ce && done_fwd) begin
            int_cfg.ram_window <= {1'b0, chain_out[21], chain_out[16:15], chain_out[20:17]};
            int_cfg.rom_window <= {1'b0, chain_out[14], chain_out[9:8], chain_out[13:10]};
            int_cfg.io_window <= {3'b000, chain_out[7:4], 1'b0};
            int_cfg.general <= {1'b0, chain_out[2], 2'b00, chain_out[1:0], 2'b00};
        end else if (ce && done_rev) begin
            int_cfg <= int_defaults;
        end
    end

    // low from the activating write until the new image has landed
    always_ff @(posedge clk) begin
        if (rst) begin
            device_active <= 1'b0;
        end else if (ce && start_fwd) begin
            device_active <= 1'b0;
        end else if (ce && done_fwd) begin
            device_active <= activate;
        end
    end

    // registered, so it rises together with busy after the launch and falls one cycle after busy
    always_ff @(posedge clk) begin
        if (rst) begin
            chain_busy <= 1'b0;
        end else if (ce) begin
            chain_busy <= busy || start_fwd || start_rev;
        end
    end

    // ****************************************
    // resource string byte and reads
    // ****************************************
    // a read clears valid first; the refill waits a cycle, so no stale flag shows
    logic rd_res;
    assign rd_res = ce && host.data_rd && cfg_ok && index == `PCT_IDX_RES_BYTE;
    always_ff @(posedge clk) begin
        if (rst) begin
            res_hold <= '0;
            res_valid <= 1'b0;
            res_byte_taken <= 1'b0;
        end else if (ce) begin
            res_byte_taken <= 1'b0;
            if (rd_res) begin
                res_valid <= 1'b0;
            end else if (!res_valid && res_byte_avail && cfg_ok && !res_byte_taken) begin
                res_hold <= res_byte_in;
                res_valid <= 1'b1;
                res_byte_taken <= 1'b1;
            end
        end
    end

    // unknown indexes and unused bits fall through to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (ce && host.data_rd) begin
            rdata <= 8'h00;
            if (cfg_ok) begin
                unique case (index)
                    `PCT_IDX_RES_BYTE: rdata <= res_hold;
                    `PCT_IDX_RES_STAT: rdata <= {7'h00, res_valid};
                    `PCT_IDX_ACTIVATE: rdata <= {7'h00, activate};
                    `PCT_IDX_RAM_HI: rdata <= {6'h00, ram_hi};
                    `PCT_IDX_RAM_LO: rdata <= {ram_lo, 5'h00};
                    `PCT_IDX_RAM_SIZE: rdata <= {1'b0, ram_size, 5'h00};
                    `PCT_IDX_ROM_HI: rdata <= rom_off ? 8'h00 : {6'h00, rom_hi};
                    `PCT_IDX_ROM_LO: rdata <= rom_off ? 8'h00 : {rom_lo, 5'h00};
                    `PCT_IDX_ROM_SIZE: rdata <= rom_off ? 8'h00 : {1'b0, rom_size, 5'h00};
                    `PCT_IDX_IO_HI: rdata <= {7'h00, io_hi};
                    `PCT_IDX_IO_LO: rdata <= {io_lo, 5'h00};
                    `PCT_IDX_IRQ: rdata <= {4'h0, irq_level};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/pct_loader_sva.sv */
// port assertions for the pnp configuration loader
// assumes bind onto pct_loader; host strobes last one clock
`default_nettype none
module pct_loader_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire pct_pkg::pct_host_s host,
    input wire pct_pkg::pct_pnp_state_e pnp_state,
    input wire logic io_pipe_mode,
    input wire logic [7:0] rdata,
    input wire pct_pkg::pct_internal_s int_cfg,
    input wire logic device_active,
    input wire logic chain_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    import pct_pkg::*;
    // ****************
    // helper state
    // ****************
    logic [7:0] idx;
    logic [4:0] run;
    logic rd_ok;
    // own copy of the index, so reads can be judged by target
    always_ff @(posedge clk) begin
        if (rst) begin
            idx <= 8'h00;
        end else if (ce && host.addr_wr) begin
            idx <= host.wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || !chain_busy) begin
            run <= 5'h00;
        end else if (ce) begin
            run <= run + 5'h01;
        end
    end
    assign rd_ok = ce && host.data_rd && pnp_state == PCT_CONFIG;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ****************
    // properties
    // ****************
    sequence s_act;
        ce && host.data_wr && idx == 8'h30 && host.wdata[0] && !chain_busy
            && !io_pipe_mode && pnp_state == PCT_CONFIG;
    endsequence
    sequence s_shift;
        ##2 !device_active ##22 device_active;
    endsequence
    property p_start; s_act |=> ##[0:1] chain_busy; endproperty
    property p_live; s_act |-> s_shift; endproperty
    // the 22 shift cycles plus the cycle after the last shift
    property p_len; $fell(chain_busy) |-> run == 5'h17; endproperty
    property p_rise; $rose(device_active) |-> $past(chain_busy); endproperty
    property p_refuse;
        ce && host.data_wr && idx == 8'h30 && host.wdata[0] && !chain_busy
            && pnp_state != PCT_CONFIG |=> !chain_busy [*3];
    endproperty
    property p_unimpl; rd_ok && idx[7:4] == 4'hf |=> rdata == 8'h00; endproperty
    property p_pipe; rd_ok && io_pipe_mode |=> rdata == 8'h00; endproperty
    property p_rom;
        rd_ok && idx inside {8'h48, 8'h49, 8'h4c} && int_cfg.rom_window[5:4] == 2'b11
            |=> rdata == 8'h00;
    endproperty
    a_start: assert property (p_start)
        else $error("activation did not start the chain");
    a_live: assert property (p_live)
        else $error("device not active after transfer");
    a_len: assert property (p_len)
        else $error("chain length differs from expected");
    a_rise: assert property (p_rise)
        else $error("device active without a transfer");
    a_refuse: assert property (p_refuse)
        else $error("activation accepted outside configuration");
    a_unimpl: assert property (p_unimpl)
        else $error("unused index read nonzero");
    a_pipe: assert property (p_pipe)
        else $error("pipe mode read nonzero");
    a_rom: assert property (p_rom)
        else $error("disabled rom register read nonzero");
endmodule
bind pct_loader pct_loader_sva pct_loader_sva_inst (.clk(clk), .rst(rst), .ce(ce), .host(host),
    .pnp_state(pnp_state), .io_pipe_mode(io_pipe_mode), .rdata(rdata), .int_cfg(int_cfg),
    .device_active(device_active), .chain_busy(chain_busy));
`default_nettype wire

/* File: test/pct_host_model.sv */
// host software model driving the pnp address and data ports
// assumes one clock; strobes change only at the falling edge
`default_nettype none
module pct_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output var pct_pkg::pct_host_s host
);
    timeunit 1ns;
    timeprecision 1ps;
    import pct_pkg::*;
    initial host = '0;
    // released data shows the inverse, so stale values never look valid
    task automatic put(input logic a, input logic d, input logic r, input logic [7:0] v);
        @(negedge clk);
        host <= '{a, d, r, v};
        @(negedge clk);
        host <= '{1'b0, 1'b0, 1'b0, ~v};
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        put(1'b1, 1'b0, 1'b0, idx);
        put(1'b0, 1'b1, 1'b0, v);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        put(1'b1, 1'b0, 1'b0, idx);
        put(1'b0, 1'b0, 1'b1, 8'h00);
        @(negedge clk);
        v = rdata;
    endtask
    task automatic get_byte(output logic [7:0] v, output logic ok);
        logic [7:0] st;
        int i;
        ok = 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            rd(8'h05, st);
            ok = st[0] === 1'b1;
        end
        rd(8'h04, v);
    endtask
endmodule
`default_nettype wire

/* File: test/pct_loader_bench.sv */
// self-checking bench for the pnp configuration loader
// assumes the host model drives every port strobe
`default_nettype none
module pct_loader_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pct_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic pipe = 1'b0;
    logic avail = 1'b0;
    logic eld = 1'b0;
    logic [7:0] rbyte = 8'h5a;
    pct_pnp_state_e st = PCT_CONFIG;
    pct_internal_s dflt = {8'h4d, 8'h00, 8'h14, 8'h08};
    pct_host_s host;
    pct_internal_s cfg;
    logic [7:0] rdata;
    logic taken;
    logic active;
    logic busy;
    int fails = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    pct_host_model pct_host_model_inst (.clk(clk), .rdata(rdata), .host(host));
    pct_loader pct_loader_inst (.clk(clk), .rst(rst), .ce(ce), .host(host), .pnp_state(st),
        .io_pipe_mode(pipe), .res_byte_in(rbyte), .res_byte_avail(avail),
        .eerom_load_done(eld), .int_defaults(dflt), .rdata(rdata), .res_byte_taken(taken),
        .int_cfg(cfg), .device_active(active), .chain_busy(busy));
    // ****************
    // shared tasks
    // ****************
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        pct_host_model_inst.rd(idx, v);
        chk(v, exp);
    endtask
    task automatic settle();
        int i;
        repeat (3) @(negedge clk);
        for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
        if (i == 40) begin
            fails++;
            $display("MISMATCH %0t shift chain hung", $time);
            wrap_up();
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reverse();
        logic [7:0] idx [7] = '{8'h40, 8'h41, 8'h44, 8'h4c, 8'h60, 8'h61, 8'h70};
        logic [7:0] exp [7] = '{8'h03, 8'ha0, 8'h60, 8'h60, 8'h01, 8'h40, 8'h03};
        eld = 1'b1;
        settle();
        foreach (idx[i]) rchk(idx[i], exp[i]);
    endtask
    task automatic t_string();
        logic [7:0] v;
        logic ok;
        int i;
        avail = 1'b1;
        for (i = 0; i < 20 && taken !== 1'b1; i++) @(negedge clk);
        avail = 1'b0;
        if (i == 20) begin
            fails++;
            $display("MISMATCH %0t resource byte never taken", $time);
            wrap_up();
        end
        pct_host_model_inst.get_byte(v, ok);
        chk({7'h00, ok}, 8'h01);
        chk(v, 8'h5a);
        rchk(8'h05, 8'h00);
    endtask
    task automatic t_activate();
        logic [7:0] lvl [9] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0f};
        logic [2:0] code [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h5, 3'h6, 3'h7};
        logic [1:0] sz [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
        foreach (lvl[i]) begin
            pct_host_model_inst.wr(8'h40, 8'h02);
            pct_host_model_inst.wr(8'h41, 8'h80);
            pct_host_model_inst.wr(8'h44, 8'((i % 4) * 32));
            pct_host_model_inst.wr(8'h70, lvl[i]);
            pct_host_model_inst.wr(8'h30, 8'h01);
            settle();
            chk({1'b0, cfg.ram_window[6:0]}, {2'b01, sz[i % 4], 4'b0100});
            chk({5'h00, cfg.general[6], cfg.general[3:2]}, {5'h00, code[i]});
            chk({7'h00, active}, 8'h01);
        end
    endtask
    task automatic t_refuse();
        st = PCT_SLEEP;
        pct_host_model_inst.wr(8'h70, 8'h00);
        pct_host_model_inst.wr(8'h30, 8'h01);
        st = PCT_CONFIG;
        rchk(8'h70, 8'h0f);
        pipe = 1'b1;
        pct_host_model_inst.wr(8'h70, 8'h00);
        rchk(8'h70, 8'h00);
        pipe = 1'b0;
        rchk(8'h70, 8'h0f);
        rchk(8'hf3, 8'h00);
        ce = 1'b0;
        rchk(8'h70, 8'h00);
        ce = 1'b1;
    endtask
    task automatic t_rom();
        pct_host_model_inst.wr(8'h48, 8'h03);
        pct_host_model_inst.wr(8'h4c, 8'h20);
        pct_host_model_inst.wr(8'h60, 8'h01);
        pct_host_model_inst.wr(8'h61, 8'h40);
        pct_host_model_inst.wr(8'h30, 8'h01);
        settle();
        chk({4'h0, cfg.rom_window[6], cfg.rom_window[3], cfg.rom_window[5:4]}, 8'h0f);
        chk(cfg.io_window, 8'h14);
        rchk(8'h48, 8'h00);
        rchk(8'h4c, 8'h00);
        pct_host_model_inst.wr(8'h4c, 8'h00);
        pct_host_model_inst.wr(8'h30, 8'h01);
        settle();
        chk({6'h00, cfg.rom_window[5:4]}, 8'h03);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_reverse();
        t_string();
        t_activate();
        t_refuse();
        t_rom();
        wrap_up();
    end
endmodule
`default_nettype wire
